// ==== rtl/shm_defines.svh ====
/*
  Constants for the homing method sequencer: method numbers, status codes,
  timing counts. Assumes inclusion by bare name from rtl/.
*/
`ifndef SHM_DEFINES_SVH
`define SHM_DEFINES_SVH
`define SHM_METH_DOG_Z_POS 8'h01
`define SHM_METH_DOG_Z_NEG 8'h21
`define SHM_METH_CNT_Z_POS 8'h02
`define SHM_METH_CNT_Z_NEG 8'h22
`define SHM_METH_DATA_SET 8'h03
`define SHM_METH_STOP_POS 8'h04
`define SHM_METH_STOP_NEG 8'h24
`define SHM_METH_DOG_R_POS 8'h06
`define SHM_METH_DOG_R_NEG 8'h26
`define SHM_CW_START_BIT 4
`define SHM_CW_HALT_BIT 8
`define SHM_SW_TGT_BIT 10
`define SHM_SW_ATT_BIT 12
`define SHM_SW_ERR_BIT 13
`define SHM_ST_PROGRESS 3'h0
`define SHM_ST_IDLE 3'h1
`define SHM_ST_ATT_NOTGT 3'h2
`define SHM_ST_DONE 3'h3
`define SHM_ST_ERR_MOVE 3'h4
`define SHM_ST_ERR_REST 3'h5
`define SHM_WARN_INCOMPLETE 12'h905
`define SHM_STOP_TIME_NS 1000000
`define SHM_CLK_PERIOD_NS 10
`define SHM_STOP_CYCLES (`SHM_STOP_TIME_NS / `SHM_CLK_PERIOD_NS)
`endif

// ==== rtl/shm_pkg.sv ====
/*
  Types for the homing method sequencer.
  Assumes shm_defines.svh is available on the include path.
*/
package shm_pkg;
  typedef enum logic [3:0] {
    SHM_IDLE = 4'h0,
    SHM_SEEK_DOG = 4'h1,
    SHM_ON_DOG = 4'h3,
    SHM_TRAVEL = 4'h2,
    SHM_WAIT_Z = 4'h6,
    SHM_STOPPER = 4'h7,
    SHM_DONE = 4'h5,
    SHM_ERROR = 4'h4
  } shm_state_t;
endpackage

// ==== rtl/shm_sense.sv ====
/*
  Three-flop conditioner for the dog, Z-phase and stopper pins.
  Assumes pins asynchronous to sys_clk_in; a change counts when stages 2 and 3 agree.
*/
`timescale 1ns/1ps
`default_nettype none
module shm_sense #(
  parameter int N = 3
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [N-1:0] pins_in,
  shm_sense_if.src sense
);
  logic [N-1:0] s1_r, s2_r, s3_r, lvl_r;
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_sync
      always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
          s3_r[g] <= 1'b0;
          lvl_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= pins_in[g];
          s2_r[g] <= s1_r[g];
          s3_r[g] <= s2_r[g];
          if (s2_r[g] == s3_r[g]) begin
            lvl_r[g] <= s3_r[g];
          end
        end
      end
    end
  endgenerate
  logic [N-1:0] nxt;
  assign nxt = (s2_r == s3_r) ? s3_r : lvl_r;
  assign sense.dog = lvl_r[0];
  assign sense.dog_rise = nxt[0] & ~lvl_r[0];
  assign sense.dog_fall = ~nxt[0] & lvl_r[0];
  assign sense.z_pulse = nxt[1] & ~lvl_r[1];
  assign sense.stall = lvl_r[2];
endmodule
`default_nettype wire

// ==== rtl/shm_sense_if.sv ====
/*
  Interface carrying synchronised sensor levels and edges from the
  input conditioner to the sequencer. Single clock domain assumed.
*/
`timescale 1ns/1ps
`default_nettype none
interface shm_sense_if;
  logic dog;
  logic dog_rise;
  logic dog_fall;
  logic z_pulse;
  logic stall;
  modport src (output dog, output dog_rise, output dog_fall, output z_pulse, output stall);
  modport dst (input dog, input dog_rise, input dog_fall, input z_pulse, input stall);
endinterface
`default_nettype wire

// ==== rtl/shm_top.sv ====
/*
  Homing method sequencer: runs the selected homing method and reports
  status bits 13/12/10. Assumes one clock; speed profile generated elsewhere.
*/
`timescale 1ns/1ps
`default_nettype none
`include "shm_defines.svh"
module shm_top #(
  parameter int PW = 32,
  parameter int STOP_CYCLES = `SHM_STOP_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] homing_method_in,
  input wire logic [15:0] control_word_in,
  input wire logic homing_operation_mode_in,
  input wire logic op_enabled_in,
  input wire logic z_required_in,
  input wire logic travel_direction_polarity_in,
  input wire logic homing_polarity_reflect_select_in,
  input wire logic dog_in,
  input wire logic z_phase_in,
  input wire logic stopper_in,
  input wire logic target_reached_in,
  input wire logic signed [PW-1:0] position_in,
  input wire logic signed [PW-1:0] travel_dist_in,
  input wire logic signed [PW-1:0] shift_dist_in,
  output logic [15:0] status_bits_out,
  output logic move_out,
  output logic dir_neg_out,
  output logic decel_out,
  output logic halt_out,
  output logic home_set_out,
  output logic signed [PW-1:0] home_pos_out,
  output logic [11:0] warning_code_out,
  output logic warning_out
);
  shm_sense_if sense();
  shm_sense #(.N(3)) u_sense (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .pins_in({stopper_in, z_phase_in, dog_in}),
    .sense(sense)
  );

  function automatic logic meth_neg(input logic [7:0] m);
    meth_neg = m[5];
  endfunction

  function automatic logic meth_ok(input logic [7:0] m);
    case (m)
      `SHM_METH_DOG_Z_POS, `SHM_METH_DOG_Z_NEG, `SHM_METH_CNT_Z_POS,
      `SHM_METH_CNT_Z_NEG, `SHM_METH_DATA_SET, `SHM_METH_STOP_POS,
      `SHM_METH_STOP_NEG, `SHM_METH_DOG_R_POS, `SHM_METH_DOG_R_NEG: meth_ok = 1'b1;
      default: meth_ok = 1'b0;
    endcase
  endfunction

  shm_pkg::shm_state_t state_r, state_nxt;
  logic [7:0] meth_r;
  logic start_r, z_seen_r, halt_s, start_s, start_edge, dog_seen_r;
  logic signed [PW-1:0] dist_r, origin_r;
  logic [31:0] stall_cnt_r;
  logic [2:0] code;
  logic [4:0] mlo;

  assign start_s = homing_operation_mode_in & control_word_in[`SHM_CW_START_BIT];
  assign halt_s = control_word_in[`SHM_CW_HALT_BIT];
  assign start_edge = start_s & ~start_r;
  assign mlo = meth_r[4:0];

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_r <= 1'b0;
    end else begin
      start_r <= start_s;
    end
  end

  // Any Z pulse since reset
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      z_seen_r <= 1'b0;
    end else if (sense.z_pulse) begin
      z_seen_r <= 1'b1;
    end
  end

  // Warning latched at start, cleared on next good start
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      warning_out <= 1'b0;
    end else if (start_edge && state_r == shm_pkg::SHM_IDLE) begin
      warning_out <= z_required_in & ~z_seen_r;
    end
  end
  assign warning_code_out = warning_out ? `SHM_WARN_INCOMPLETE : 12'h000;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      shm_pkg::SHM_IDLE: begin
        if (start_edge) begin
          if (!meth_ok(homing_method_in)) begin
            state_nxt = shm_pkg::SHM_ERROR;
          end else if (homing_method_in == `SHM_METH_DATA_SET) begin
            state_nxt = op_enabled_in ? shm_pkg::SHM_DONE : shm_pkg::SHM_ERROR;
          end else if (z_required_in && !z_seen_r) begin
            state_nxt = shm_pkg::SHM_ERROR;
          end else if (homing_method_in[4:0] == 5'h04) begin
            state_nxt = shm_pkg::SHM_STOPPER;
          end else begin
            state_nxt = shm_pkg::SHM_SEEK_DOG;
          end
        end
      end
      shm_pkg::SHM_SEEK_DOG: begin
        if (sense.dog_rise) begin
          state_nxt = (mlo == 5'h02) ? shm_pkg::SHM_TRAVEL : shm_pkg::SHM_ON_DOG;
        end
      end
      shm_pkg::SHM_ON_DOG: begin
        if (sense.dog_fall) begin
          state_nxt = (mlo == 5'h01) ? shm_pkg::SHM_WAIT_Z : shm_pkg::SHM_TRAVEL;
        end
      end
      shm_pkg::SHM_TRAVEL: begin
        if (dist_r >= travel_dist_in) begin
          state_nxt = (mlo == 5'h02) ? shm_pkg::SHM_WAIT_Z : shm_pkg::SHM_DONE;
        end
      end
      shm_pkg::SHM_WAIT_Z: begin
        if (sense.z_pulse) begin
          state_nxt = shm_pkg::SHM_DONE;
        end
      end
      shm_pkg::SHM_STOPPER: begin
        if (stall_cnt_r >= 32'(STOP_CYCLES - 1)) begin
          state_nxt = shm_pkg::SHM_DONE;
        end
      end
      shm_pkg::SHM_DONE, shm_pkg::SHM_ERROR: begin
        if (start_edge) begin
          state_nxt = shm_pkg::SHM_IDLE;
        end
      end
      default: state_nxt = shm_pkg::SHM_IDLE;
    endcase
    // Dropping the start bit mid-sequence interrupts it
    if (!start_s && state_r != shm_pkg::SHM_DONE && state_r != shm_pkg::SHM_ERROR) begin
      state_nxt = shm_pkg::SHM_IDLE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= shm_pkg::SHM_IDLE;
    end else if (!halt_s || state_nxt == shm_pkg::SHM_IDLE) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meth_r <= 8'h00;
      dog_seen_r <= 1'b0;
    end else if (state_r == shm_pkg::SHM_IDLE && start_edge) begin
      meth_r <= homing_method_in;
      dog_seen_r <= 1'b0;
    end else if (sense.dog_rise) begin
      dog_seen_r <= 1'b1;
    end
  end

  // Travel distance measured from the edge that opens the count
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      origin_r <= '0;
      dist_r <= '0;
    end else if (state_r != shm_pkg::SHM_TRAVEL) begin
      origin_r <= position_in;
      dist_r <= '0;
    end else begin
      dist_r <= meth_neg(meth_r) ? (origin_r - position_in) : (position_in - origin_r);
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stall_cnt_r <= 32'h0000_0000;
    end else if (state_r == shm_pkg::SHM_STOPPER && sense.stall) begin
      stall_cnt_r <= stall_cnt_r + 32'h0000_0001;
    end else begin
      stall_cnt_r <= 32'h0000_0000;
    end
  end

  // Home position latch
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      home_pos_out <= '0;
      home_set_out <= 1'b0;
    end else begin
      home_set_out <= 1'b0;
      if (state_nxt == shm_pkg::SHM_DONE && state_r != shm_pkg::SHM_DONE && !halt_s) begin
        home_set_out <= 1'b1;
        if (mlo == 5'h03 || mlo == 5'h04) begin
          home_pos_out <= position_in;
        end else begin
          home_pos_out <= position_in + shift_dist_in;
        end
      end
    end
  end

  logic moving;
  assign moving = state_r == shm_pkg::SHM_SEEK_DOG || state_r == shm_pkg::SHM_ON_DOG ||
                  state_r == shm_pkg::SHM_TRAVEL || state_r == shm_pkg::SHM_WAIT_Z ||
                  state_r == shm_pkg::SHM_STOPPER;

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      move_out <= 1'b0;
      dir_neg_out <= 1'b0;
      decel_out <= 1'b0;
      halt_out <= 1'b0;
    end else begin
      move_out <= moving & ~halt_s;
      halt_out <= halt_s;
      dir_neg_out <= meth_neg(meth_r) ^
                     (travel_direction_polarity_in & homing_polarity_reflect_select_in);
      decel_out <= moving && dog_seen_r && state_r != shm_pkg::SHM_STOPPER;
    end
  end

  always_comb begin
    case (state_r)
      shm_pkg::SHM_IDLE: code = `SHM_ST_IDLE;
      shm_pkg::SHM_DONE: code = target_reached_in ? `SHM_ST_DONE : `SHM_ST_ATT_NOTGT;
      shm_pkg::SHM_ERROR: code = `SHM_ST_ERR_REST;
      default: code = halt_s ? `SHM_ST_IDLE : `SHM_ST_PROGRESS;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_bits_out <= 16'h0400;
    end else begin
      status_bits_out <= 16'h0000;
      status_bits_out[`SHM_SW_ERR_BIT] <= code[2];
      status_bits_out[`SHM_SW_ATT_BIT] <= code[1];
      status_bits_out[`SHM_SW_TGT_BIT] <= code[0];
    end
  end

  property p_unsupported;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (state_r == shm_pkg::SHM_IDLE && start_edge && !meth_ok(homing_method_in))
      |=> state_r == shm_pkg::SHM_ERROR ##1 (!move_out && status_bits_out[13]);
  endproperty
  a_unsupported: assert property (p_unsupported) else $error("bad method not refused");

  property p_dataset_off;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (state_r == shm_pkg::SHM_IDLE && start_edge && !op_enabled_in &&
     homing_method_in == `SHM_METH_DATA_SET) |=> state_r == shm_pkg::SHM_ERROR;
  endproperty
  a_dataset_off: assert property (p_dataset_off) else $error("data set ran servo off");

  property p_warn;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (state_r == shm_pkg::SHM_IDLE && start_edge && z_required_in && !z_seen_r)
      |=> warning_out && warning_code_out == `SHM_WARN_INCOMPLETE;
  endproperty
  a_warn: assert property (p_warn) else $error("missing incomplete warning");

  property p_dir;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    ##1 dir_neg_out == ($past(meth_r[5]) ^
      ($past(travel_direction_polarity_in) & $past(homing_polarity_reflect_select_in)));
  endproperty
  a_dir: assert property (p_dir) else $error("direction polarity wrong");

  property p_z_home;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (state_r == shm_pkg::SHM_WAIT_Z && sense.z_pulse && start_s && !halt_s)
      |=> home_set_out && home_pos_out == $past(position_in) + $past(shift_dist_in);
  endproperty
  a_z_home: assert property (p_z_home) else $error("Z home not latched");

  property p_stop_noshift;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (home_set_out && meth_r[4:0] == 5'h04) |-> home_pos_out == $past(position_in);
  endproperty
  a_stop_noshift: assert property (p_stop_noshift) else $error("stopper shifted");

  property p_rear;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (state_r == shm_pkg::SHM_ON_DOG && sense.dog_fall && start_s && !halt_s &&
     meth_r[4:0] == 5'h06) |=> state_r == shm_pkg::SHM_TRAVEL;
  endproperty
  a_rear: assert property (p_rear) else $error("rear edge not followed");

  property p_count;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (state_r == shm_pkg::SHM_TRAVEL && dist_r >= travel_dist_in && start_s && !halt_s &&
     meth_r[4:0] == 5'h02) |=> state_r == shm_pkg::SHM_WAIT_Z;
  endproperty
  a_count: assert property (p_count) else $error("count travel not ended");

  property p_status;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (state_r == shm_pkg::SHM_IDLE) |=> status_bits_out[13:10] == 4'h1;
  endproperty
  a_status: assert property (p_status) else $error("idle status wrong");

  property p_halt;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    halt_s |=> !move_out && halt_out;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not obeyed");

  property p_method;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (state_r == shm_pkg::SHM_IDLE && start_edge) |=> meth_r == $past(homing_method_in);
  endproperty
  a_method: assert property (p_method) else $error("method not captured");
endmodule
`default_nettype wire

// ==== test/shm_ctrl_model.sv ====
/*
  Behavioural motion controller that writes method, control word and mode.
  Assumes the sequencer samples its inputs on the rising edge of sys_clk_in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "shm_defines.svh"
module shm_ctrl_model #(
  parameter bit HAS_Z = 1'b1
) (
  input wire logic sys_clk_in,
  output logic [7:0] homing_method_out,
  output logic [15:0] control_word_out,
  output logic homing_operation_mode_out
);
  logic signed [31:0] target_pos_r;
  initial begin
    homing_method_out = 8'h00;
    control_word_out = 16'h0000;
    homing_operation_mode_out = 1'b0;
    target_pos_r = 32'sh00000001;
  end
  // Method held with the start bit in homing mode
  task automatic start(input logic [7:0] m);
    @(posedge sys_clk_in);
    // Without Z only data set or stopper methods
    if (HAS_Z || (m inside {`SHM_METH_DATA_SET, `SHM_METH_STOP_POS, `SHM_METH_STOP_NEG})) begin
      homing_method_out <= m;
      homing_operation_mode_out <= 1'b1;
      control_word_out[`SHM_CW_START_BIT] <= 1'b1;
    end
  endtask
  task automatic set_start(input logic b);
    @(posedge sys_clk_in);
    control_word_out[`SHM_CW_START_BIT] <= b;
  endtask
  task automatic set_halt(input logic b);
    @(posedge sys_clk_in);
    control_word_out[`SHM_CW_HALT_BIT] <= b;
  endtask
  // Target cleared before the mode changes
  task automatic leave_homing();
    @(posedge sys_clk_in);
    target_pos_r <= 32'sh00000000;
    @(posedge sys_clk_in);
    homing_operation_mode_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== test/shm_tb_top.sv ====
/*
  Self-checking bench for the homing method sequencer.
  Assumes shm_top with plain ports and the controller model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "shm_defines.svh"
module shm_tb_top;
  logic sys_clk, nrst, op_en, z_req, direction_invert_setting, refl, dog, zph, stp, tgt;
  logic signed [31:0] pos, trav, shf, hp;
  logic [7:0] meth;
  logic [15:0] cw, sts;
  logic mode, mv, dneg, dec, hlt, hs, wo;
  logic [11:0] wc;
  int fails, n_checks;
  shm_ctrl_model ctl (.sys_clk_in(sys_clk), .homing_method_out(meth), .control_word_out(cw),
    .homing_operation_mode_out(mode));
  shm_top #(.PW(32), .STOP_CYCLES(8)) dut (.sys_clk_in(sys_clk), .nrst_in(nrst),
    .homing_method_in(meth), .control_word_in(cw), .homing_operation_mode_in(mode),
    .op_enabled_in(op_en), .z_required_in(z_req), .travel_direction_polarity_in(direction_invert_setting),
    .homing_polarity_reflect_select_in(refl), .dog_in(dog), .z_phase_in(zph),
    .stopper_in(stp), .target_reached_in(tgt), .position_in(pos), .travel_dist_in(trav),
    .shift_dist_in(shf), .status_bits_out(sts), .move_out(mv), .dir_neg_out(dneg),
    .decel_out(dec), .halt_out(hlt), .home_set_out(hs), .home_pos_out(hp),
    .warning_code_out(wc), .warning_out(wo));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic bad(input string s);
    fails++;
    $display("wrong value at %0t: %s", $time, s);
  endtask
  task automatic chk_sts(input logic [2:0] s);
    logic [15:0] e;
    e = 16'h0000;
    e[`SHM_SW_ERR_BIT] = s[2];
    e[`SHM_SW_ATT_BIT] = s[1];
    e[`SHM_SW_TGT_BIT] = s[0];
    n_checks++;
    if (sts !== e) bad($sformatf("status %h expected %h", sts, e));
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) bad($sformatf("flag %b expected %b", got, exp));
  endtask
  task automatic chk_val(input logic signed [31:0] got, input logic signed [31:0] exp);
    n_checks++;
    if (got !== exp) bad($sformatf("value %0d expected %0d", got, exp));
  endtask
  task automatic pins(input logic d, input logic z, input logic s);
    @(posedge sys_clk);
    dog <= d;
    zph <= z;
    stp <= s;
  endtask
  task automatic watch_home(input logic want, input logic signed [31:0] e, input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      tick(1);
      if (hs === 1'b1) begin
        seen = 1'b1;
        chk_val(hp, e);
      end
    end
    chk_bit(seen, want);
  endtask
  task automatic z_pulse(input logic want, input logic signed [31:0] e);
    pins(dog, 1'b1, 1'b0);
    watch_home(want, e, 8);
    pins(dog, 1'b0, 1'b0);
    tick(4);
  endtask
  task automatic go_idle();
    pins(1'b0, 1'b0, 1'b0);
    ctl.set_start(1'b0);
    tick(3);
    if (sts[12] === 1'b1 || sts[13] === 1'b1) begin
      ctl.set_start(1'b1);
      tick(3);
      ctl.set_start(1'b0);
      tick(3);
    end
    chk_sts(`SHM_ST_IDLE);
  endtask
  task automatic t_warn();
    @(posedge sys_clk);
    z_req <= 1'b1;
    ctl.start(`SHM_METH_DOG_Z_POS);
    tick(3);
    chk_sts(`SHM_ST_ERR_REST);
    chk_bit(mv, 1'b0);
    chk_bit(wo, 1'b1);
    chk_val({20'h00000, wc}, {20'h00000, 12'h905});
    go_idle();
    z_pulse(1'b0, 32'sh0);
    ctl.start(`SHM_METH_DATA_SET);
    watch_home(1'b1, pos, 4);
    chk_bit(wo, 1'b0);
    go_idle();
    $display("test warn done");
  endtask
  task automatic t_data_set();
    @(posedge sys_clk);
    op_en <= 1'b0;
    ctl.start(`SHM_METH_DATA_SET);
    tick(3);
    chk_sts(`SHM_ST_ERR_REST);
    go_idle();
    @(posedge sys_clk);
    op_en <= 1'b1;
    pos <= 32'sd1234;
    ctl.start(`SHM_METH_DATA_SET);
    watch_home(1'b1, 32'sd1234, 4);
    chk_sts(`SHM_ST_ATT_NOTGT);
    @(posedge sys_clk);
    tgt <= 1'b1;
    tick(2);
    chk_sts(`SHM_ST_DONE);
    go_idle();
    $display("test data set done");
  endtask
  task automatic t_unsup();
    ctl.start(8'h05);
    tick(3);
    chk_sts(`SHM_ST_ERR_REST);
    chk_bit(mv, 1'b0);
    go_idle();
    $display("test unsupported done");
  endtask
  task automatic t_dog(input logic [7:0] m, input logic neg);
    @(posedge sys_clk);
    pos <= 32'sd500;
    shf <= 32'sd7;
    ctl.start(m);
    tick(3);
    chk_sts(`SHM_ST_PROGRESS);
    chk_bit(mv, 1'b1);
    chk_bit(dneg, neg);
    chk_bit(dec, 1'b0);
    pins(1'b1, 1'b0, 1'b0);
    tick(6);
    chk_bit(dec, 1'b1);
    z_pulse(1'b0, 32'sh0);
    pins(1'b0, 1'b0, 1'b0);
    tick(6);
    z_pulse(1'b1, 32'sd507);
    go_idle();
    $display("test dog z done");
  endtask
  task automatic t_count(input logic [7:0] m, input logic neg);
    @(posedge sys_clk);
    pos <= 32'sd1000;
    trav <= 32'sd50;
    shf <= 32'sd3;
    ctl.start(m);
    tick(3);
    chk_bit(dneg, neg);
    pins(1'b1, 1'b0, 1'b0);
    tick(6);
    chk_bit(dec, 1'b1);
    z_pulse(1'b0, 32'sh0);
    @(posedge sys_clk);
    pos <= neg ? 32'sd950 : 32'sd1050;
    tick(3);
    z_pulse(1'b1, neg ? 32'sd953 : 32'sd1053);
    go_idle();
    $display("test count done");
  endtask
  task automatic t_rear(input logic [7:0] m, input logic neg);
    @(posedge sys_clk);
    pos <= 32'sd200;
    trav <= 32'sd40;
    shf <= 32'sd5;
    ctl.start(m);
    tick(3);
    chk_bit(dneg, neg);
    pins(1'b1, 1'b0, 1'b0);
    tick(6);
    pins(1'b0, 1'b0, 1'b0);
    watch_home(1'b0, 32'sh0, 8);
    @(posedge sys_clk);
    pos <= neg ? 32'sd160 : 32'sd240;
    watch_home(1'b1, neg ? 32'sd165 : 32'sd245, 8);
    go_idle();
    $display("test dog rear done");
  endtask
  task automatic t_stop(input logic [7:0] m, input logic neg);
    @(posedge sys_clk);
    pos <= -32'sd300;
    shf <= 32'sd9;
    ctl.start(m);
    tick(3);
    chk_bit(dneg, neg);
    pins(1'b0, 1'b0, 1'b1);
    tick(2);
    pins(1'b0, 1'b0, 1'b0);
    watch_home(1'b0, 32'sh0, 10);
    pins(1'b0, 1'b0, 1'b1);
    watch_home(1'b1, -32'sd300, 20);
    go_idle();
    $display("test stopper done");
  endtask
  task automatic t_pol(input logic r, input logic [7:0] m, input logic neg);
    @(posedge sys_clk);
    direction_invert_setting <= 1'b1;
    refl <= r;
    ctl.start(m);
    tick(3);
    chk_bit(dneg, neg);
    go_idle();
    @(posedge sys_clk);
    direction_invert_setting <= 1'b0;
    $display("test polarity done");
  endtask
  task automatic t_halt();
    ctl.start(`SHM_METH_DOG_Z_POS);
    tick(3);
    ctl.set_halt(1'b1);
    tick(3);
    chk_bit(hlt, 1'b1);
    chk_bit(mv, 1'b0);
    chk_sts(`SHM_ST_IDLE);
    ctl.set_halt(1'b0);
    tick(3);
    chk_bit(mv, 1'b1);
    ctl.set_start(1'b0);
    tick(3);
    chk_sts(`SHM_ST_IDLE);
    chk_bit(mv, 1'b0);
    ctl.leave_homing();
    // Start bit outside homing mode must not start a sequence
    ctl.set_start(1'b1);
    tick(3);
    chk_sts(`SHM_ST_IDLE);
    chk_bit(mv, 1'b0);
    $display("test halt done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad("watchdog expired");
    print_verdict();
  end
  initial begin
    nrst = 1'b0;
    op_en = 1'b1;
    z_req = 1'b0;
    direction_invert_setting = 1'b0;
    refl = 1'b0;
    dog = 1'b0;
    zph = 1'b0;
    stp = 1'b0;
    tgt = 1'b0;
    {pos, trav, shf} = {32'sh0, 32'sh0, 32'sh0};
    fails = 0;
    n_checks = 0;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    tick(5);
    chk_sts(`SHM_ST_IDLE);
    chk_bit(mv, 1'b0);
    t_warn();
    t_data_set();
    t_unsup();
    t_dog(`SHM_METH_DOG_Z_POS, 1'b0);
    t_dog(`SHM_METH_DOG_Z_NEG, 1'b1);
    t_count(`SHM_METH_CNT_Z_POS, 1'b0);
    t_count(`SHM_METH_CNT_Z_NEG, 1'b1);
    t_rear(`SHM_METH_DOG_R_POS, 1'b0);
    t_rear(`SHM_METH_DOG_R_NEG, 1'b1);
    t_stop(`SHM_METH_STOP_POS, 1'b0);
    t_stop(`SHM_METH_STOP_NEG, 1'b1);
    t_pol(1'b1, `SHM_METH_DOG_Z_POS, 1'b1);
    t_pol(1'b0, `SHM_METH_DOG_Z_POS, 1'b0);
    t_pol(1'b1, `SHM_METH_DOG_Z_NEG, 1'b0);
    t_halt();
    print_verdict();
  end
endmodule
`default_nettype wire
